// *** hw/lfr_regs.sv ***
// Control, status and interrupt registers of the wake-up receiver
`timescale 1ns/1ps
// What this block does
// RULE1: Data-ready flag with enable bit 7 requests an interrupt.
// RULE2: Receive-error flag with enable bit 6 requests an interrupt.
// RULE3: Carrier-detect flag with enable bit 5 requests an interrupt.
// RULE4: ID-match flag with enable bit 4 requests an interrupt.
// RULE5: Decoder enable bit 3 low stops frame checks and data, error, ID flags.
// RULE6: With decoder off software polls the detector output bit.
// RULE7: Carrier validation runs only while bit 2 is set.
// RULE8: Timeout field picks no limit, 8, 24 or 48 ms SYNC search.
// RULE9: No SYNC before timeout switches the receiver off.
// RULE10: Timeout counts oscillator ticks, not bus clock cycles.
// RULE11: Power-on or soft reset loads control 0x0F; other resets keep it.
// RULE12: Status bits 7..2 read-only flags, bit 1 mode, bit 0 ack, reset 0x02.
// RULE13: Writing one to ack clears error, carrier and ID flags.
// RULE14: Data ready sets on a byte, clears on ack or data read.
// RULE15: Detector output bit is read-only and follows the slicer.
// RULE16: One level interrupt is OR of flag AND enable, held until cleared.
// RULE17: Enables, decoder, validation and timeout read back as written.
module lfr_regs
  import lfr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic softReset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  input wire lfr_events_t rxEvents,
  input wire logic [7:0] rxByte,
  input wire logic syncFound,
  input wire logic searchStart,
  input wire logic oscTick,
  input wire logic detectorOutPin,
  output logic digitalDecoderEnable,
  output logic carrierValidationEnable,
  output logic receiverOff,
  output logic irqOut
);
  logic [7:0] ctl_reg;
  logic [5:0] flags_reg;
  logic modeBit_reg;
  logic [5:0] evtMask_reg;
  logic [5:0] evtSticky_reg;
  logic [7:0] data_reg;
  logic [7:0] tmoCount_reg;
  logic searching_reg;
  logic rxOff_reg;
  logic detSync1_reg;
  logic detSync2_reg;
  logic tickSync1_reg;
  logic tickSync2_reg;
  logic tickPrev_reg;

  // Register decode
  wire logic wrCtl = regWrite && (regAddr == LFR_CTL_ADDR);
  wire logic wrSts = regWrite && (regAddr == LFR_STS_ADDR);
  wire logic wrIrq = regWrite && (regAddr == LFR_IRQ_ADDR);
  wire logic wrMsk = regWrite && (regAddr == LFR_MSK_ADDR);
  wire logic rdDat = regRead && (regAddr == LFR_DAT_ADDR);
  // RULE13: ack write
  wire logic ackWrite = wrSts && regWrData[LFR_BIT_ACK];

  // RULE5: gate decoder flags
  wire logic decOn = ctl_reg[LFR_BIT_DIGITAL_DECODER_ENABLE];
  wire logic setDr = rxEvents.dataReady && decOn;
  wire logic setEr = rxEvents.rxError && decOn;
  wire logic setId = rxEvents.idMatch && decOn;
  wire logic setOv = rxEvents.overflow && decOn;
  wire logic setEom = rxEvents.endOfMessage && decOn;
  wire logic setCd = rxEvents.carrierDetect;
  wire logic [5:0] setVec = {setDr, setEr, setCd, setId, setOv, setEom};

  // RULE14: data ready clear terms
  wire logic clrDr = ackWrite || rdDat;
  wire logic [5:0] clrVec = {clrDr, ackWrite, ackWrite, ackWrite, ackWrite, ackWrite};
  // Set wins over clear for every flag
  wire logic [5:0] flagsNext = setVec | (flags_reg & ~clrVec);

  // RULE16: flag and enable OR
  wire logic [3:0] irqEn = ctl_reg[7:4];
  // RULE1: data ready term
  wire logic irqDr = flags_reg[5] && irqEn[3];
  // RULE2: error term
  wire logic irqEr = flags_reg[4] && irqEn[2];
  // RULE3: carrier term
  wire logic irqCd = flags_reg[3] && irqEn[1];
  // RULE4: ID term
  wire logic irqId = flags_reg[2] && irqEn[0];
  wire logic irqStickyAny = |(evtSticky_reg & evtMask_reg);
  assign irqOut = irqDr || irqEr || irqCd || irqId || irqStickyAny;

  // RULE7: validation enable out
  assign carrierValidationEnable = ctl_reg[LFR_BIT_CARRIER_VALIDATION_ENABLE];
  assign digitalDecoderEnable = decOn;
  assign receiverOff = rxOff_reg;

  // RULE8: timeout selection
  wire logic [1:0] tmoSel = ctl_reg[1:0];
  wire logic [7:0] tmoLimit = (tmoSel == 2'b01) ? LFR_TMO1_TICKS :
                              (tmoSel == 2'b10) ? LFR_TMO2_TICKS : LFR_TMO3_TICKS;
  // RULE10: oscillator tick edge
  wire logic tickEdge = tickSync2_reg && !tickPrev_reg;
  // RULE9: expiry switches off
  wire logic tmoHit = searching_reg && (tmoSel != 2'b00) && tickEdge && (tmoCount_reg + 8'h01 >= tmoLimit);

  // RULE12: status readback
  wire logic [7:0] stsRead = {flags_reg, modeBit_reg, 1'b0};
  // RULE17: control readback
  wire logic [7:0] rdMux = (regAddr == LFR_CTL_ADDR) ? ctl_reg :
                           (regAddr == LFR_STS_ADDR) ? stsRead :
                           (regAddr == LFR_IRQ_ADDR) ? {2'b00, evtSticky_reg} :
                           (regAddr == LFR_MSK_ADDR) ? {2'b00, evtMask_reg} :
                           (regAddr == LFR_DAT_ADDR) ? data_reg :
                           (regAddr == LFR_DET_ADDR) ? {detSync2_reg, 7'h00} : 8'h00;

  // Synchronisers for the detector pin and the oscillator clock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      detSync1_reg <= 1'b0;
      detSync2_reg <= 1'b0;
      tickSync1_reg <= 1'b0;
      tickSync2_reg <= 1'b0;
      tickPrev_reg <= 1'b0;
    end else begin
      // RULE15: follow slicer
      detSync1_reg <= detectorOutPin;
      detSync2_reg <= detSync1_reg;
      tickSync1_reg <= oscTick;
      tickSync2_reg <= tickSync1_reg;
      tickPrev_reg <= tickSync2_reg;
    end
  end

  // RULE11: control register defaults
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_reg <= LFR_CTL_RESET;
    end else if (softReset) begin
      ctl_reg <= LFR_CTL_RESET;
    end else if (wrCtl) begin
      ctl_reg <= regWrData;
    end
  end

  // RULE12: status flags and mode bit
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= LFR_STS_RESET[7:2];
      modeBit_reg <= LFR_STS_RESET[LFR_BIT_MODE];
    end else if (softReset) begin
      flags_reg <= LFR_STS_RESET[7:2];
      modeBit_reg <= LFR_STS_RESET[LFR_BIT_MODE];
    end else begin
      flags_reg <= flagsNext;
      if (wrSts) begin
        modeBit_reg <= regWrData[LFR_BIT_MODE];
      end
    end
  end

  // Sticky event bits, write one to clear, set wins
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      evtSticky_reg <= 6'h00;
      evtMask_reg <= 6'h00;
    end else begin
      evtSticky_reg <= setVec | (evtSticky_reg & ~(wrIrq ? regWrData[5:0] : 6'h00));
      if (wrMsk) begin
        evtMask_reg <= regWrData[5:0];
      end
    end
  end

  // Received byte capture
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_reg <= 8'h00;
    end else if (setDr) begin
      data_reg <= rxByte;
    end
  end

  // RULE9: SYNC search timer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      searching_reg <= 1'b0;
      tmoCount_reg <= 8'h00;
      rxOff_reg <= 1'b0;
    end else if (softReset || syncFound) begin
      searching_reg <= 1'b0;
      tmoCount_reg <= 8'h00;
      rxOff_reg <= 1'b0;
    end else if (searchStart) begin
      searching_reg <= 1'b1;
      tmoCount_reg <= 8'h00;
      rxOff_reg <= 1'b0;
    end else if (tmoHit) begin
      searching_reg <= 1'b0;
      rxOff_reg <= 1'b1;
    end else if (searching_reg && tickEdge) begin
      tmoCount_reg <= tmoCount_reg + 8'h01;
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      regRdData <= rdMux;
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule : lfr_regs

// *** hw/lfr_pkg.sv ***
// Package for the wake-up receiver control and status register bank
package lfr_pkg;
  localparam logic [7:0] LFR_CTL_ADDR = 8'h23;
  localparam logic [7:0] LFR_STS_ADDR = 8'h24;
  localparam logic [7:0] LFR_IRQ_ADDR = 8'h25;
  localparam logic [7:0] LFR_MSK_ADDR = 8'h26;
  localparam logic [7:0] LFR_DAT_ADDR = 8'h27;
  localparam logic [7:0] LFR_DET_ADDR = 8'h22;
  localparam logic [7:0] LFR_CTL_RESET = 8'h0F;
  localparam logic [7:0] LFR_STS_RESET = 8'h02;
  localparam int LFR_BIT_DRIE = 7;
  localparam int LFR_BIT_ERIE = 6;
  localparam int LFR_BIT_CDIE = 5;
  localparam int LFR_BIT_IDIE = 4;
  localparam int LFR_BIT_DIGITAL_DECODER_ENABLE = 3;
  localparam int LFR_BIT_CARRIER_VALIDATION_ENABLE = 2;
  localparam int LFR_BIT_MODE = 1;
  localparam int LFR_BIT_ACK = 0;
  // Oscillator tick period in microseconds and search times in milliseconds
  localparam int LFR_OSC_PERIOD_US = 1000;
  localparam int LFR_TMO1_MS = 8;
  localparam int LFR_TMO2_MS = 24;
  localparam int LFR_TMO3_MS = 48;
  localparam logic [7:0] LFR_TMO1_TICKS = 8'(LFR_TMO1_MS * 1000 / LFR_OSC_PERIOD_US);
  localparam logic [7:0] LFR_TMO2_TICKS = 8'(LFR_TMO2_MS * 1000 / LFR_OSC_PERIOD_US);
  localparam logic [7:0] LFR_TMO3_TICKS = 8'(LFR_TMO3_MS * 1000 / LFR_OSC_PERIOD_US);
  typedef struct packed {
    logic dataReady;
    logic rxError;
    logic carrierDetect;
    logic idMatch;
    logic overflow;
    logic endOfMessage;
  } lfr_events_t;
endpackage : lfr_pkg

// *** tb/lfr_regs_props.sv ***
// Assertion checker for the receiver register bank
`timescale 1ns/1ps
module lfr_regs_props
  import lfr_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic softReset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  input wire lfr_events_t rxEvents,
  input wire logic searchStart,
  input wire logic digitalDecoderEnable,
  input wire logic carrierValidationEnable,
  input wire logic receiverOff,
  input wire logic irqOut
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Control outputs, reset, read and interrupt relations
  AST_CTL_WR: assert property (
    regWrite && regAddr == LFR_CTL_ADDR && !softReset |=> digitalDecoderEnable == $past(regWrData[3])
    && carrierValidationEnable == $past(regWrData[2])) else $error("control bits not as written");
  AST_SOFT_CTL: assert property (
    softReset |=> digitalDecoderEnable && carrierValidationEnable) else $error("soft reset missed");
  AST_SOFT_OFF: assert property (
    softReset |=> !receiverOff) else $error("receiver off after soft reset");
  AST_START_OFF: assert property (
    searchStart && !softReset |=> !receiverOff) else $error("receiver off at search start");
  AST_STS_BIT0: assert property (
    regRead && regAddr == LFR_STS_ADDR |=> !regRdData[0]) else $error("ack bit reads one");
  AST_RD_IDLE: assert property (
    !$past(regRead) |-> regRdData == 8'h00) else $error("read data outside read cycle");
  AST_IRQ_CAUSE: assert property (
    $rose(irqOut) |-> $past(rxEvents != '0 || regWrite)) else $error("interrupt without cause");
  AST_IRQ_HOLD: assert property (
    irqOut && !regWrite && !regRead && !softReset |=> irqOut) else $error("interrupt dropped");
  AST_DEC_OFF: assert property (
    $rose(irqOut) && !$past(regWrite) && !$past(digitalDecoderEnable) |-> $past(rxEvents.carrierDetect))
    else $error("flag set with decoder off");
  // Main scenarios reached
  cover property ($rose(irqOut));
  cover property ($rose(receiverOff));
  cover property (softReset);
endmodule : lfr_regs_props
bind lfr_regs lfr_regs_props lfr_regs_props_i (.*);

// *** tb/lfr_far_model.sv ***
// Far-side model: decoder events, search start, oscillator and detector
`timescale 1ns/1ps
module lfr_far_model
  import lfr_pkg::*;
(
  input wire logic core_clk,
  output lfr_events_t rxEvents = '0,
  output logic [7:0] rxByte = 8'h00,
  output logic searchStart = 1'b0,
  output logic oscTick = 1'b0,
  output logic detectorOutPin = 1'b0
);
  // One event pulse; the byte does not stay valid after it
  task automatic pulse(input lfr_events_t e, input logic [7:0] b);
    rxEvents <= e;
    rxByte <= b;
    @(posedge core_clk);
    rxEvents <= '0;
    rxByte <= ~b;
    @(posedge core_clk);
  endtask : pulse
  // Search start pulse
  task automatic start();
    searchStart <= 1'b1;
    @(posedge core_clk);
    searchStart <= 1'b0;
    @(posedge core_clk);
  endtask : start
  task automatic ticks(input int n);
    repeat (n) begin
      oscTick <= 1'b1;
      repeat (10) @(posedge core_clk);
      oscTick <= 1'b0;
      repeat (10) @(posedge core_clk);
    end
  endtask : ticks
  task automatic detect(input logic v);
    detectorOutPin <= v;
    @(posedge core_clk);
  endtask : detect
endmodule : lfr_far_model

// *** tb/lfr_regs_tb.sv ***
// Self-checking bench for the receiver register bank
`timescale 1ns/1ps
module lfr_regs_tb;
  import lfr_pkg::*;
  logic core_clk = 1'b0, reset_n = 1'b0, softReset = 1'b0, regWrite = 1'b0, regRead = 1'b0, syncFound = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, rxByte;
  logic searchStart, oscTick, detectorOutPin, digitalDecoderEnable, carrierValidationEnable, receiverOff, irqOut;
  lfr_events_t rxEvents;
  int miscompares = 0, checks_done = 0;
  int tmo [4] = '{60, LFR_TMO1_TICKS, LFR_TMO2_TICKS, LFR_TMO3_TICKS};
  logic [23:0] rows [6] = '{24'h238080, 24'h235A5A, 24'h23F3F3, 24'h240000, 24'h40FF00, 24'h24FF02};
  lfr_regs lfr_regs_i (.*);
  lfr_far_model lfr_far_model_i (.*);
  always #5 core_clk = ~core_clk;
  // Comparisons and bus cycles
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask : chk8
  task automatic see(input logic off, input logic e);
    #1 chk8(off ? "receiverOff" : "irqOut", {7'h00, e}, {7'h00, off ? receiverOff : irqOut});
    @(posedge core_clk);
  endtask : see
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 chk8("regRdData", e, regRdData & m);
    @(posedge core_clk);
  endtask : rd
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    see(0, 1'b0);
    see(1, 1'b0);
    rd(LFR_CTL_ADDR, LFR_CTL_RESET);
    rd(LFR_STS_ADDR, LFR_STS_RESET);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    $display("readback done");
    wr(LFR_MSK_ADDR, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(LFR_CTL_ADDR, 8'h08);
      lfr_far_model_i.pulse(lfr_events_t'(6'h20 >> i), 8'hA5);
      see(0, 1'b0);
      wr(LFR_CTL_ADDR, 8'h08 | (8'h80 >> i));
      see(0, 1'b1);
      wr(LFR_STS_ADDR, 8'h03);
      see(0, 1'b0);
    end
    wr(LFR_CTL_ADDR, 8'h88);
    lfr_far_model_i.pulse(lfr_events_t'(6'h20), 8'h3C);
    rd(LFR_STS_ADDR, 8'h82);
    rd(LFR_DAT_ADDR, 8'h3C);
    see(0, 1'b0);
    rd(LFR_IRQ_ADDR, 8'h3C);
    wr(LFR_MSK_ADDR, 8'h08);
    see(0, 1'b1);
    wr(LFR_IRQ_ADDR, 8'h3C);
    see(0, 1'b0);
    wr(LFR_CTL_ADDR, 8'hF0);
    lfr_far_model_i.pulse(lfr_events_t'(6'h34), 8'h11);
    see(0, 1'b0);
    rd(LFR_STS_ADDR, 8'h02);
    $display("interrupt done");
    // Polling the raw detector level
    lfr_far_model_i.detect(1'b1);
    repeat (4) @(posedge core_clk);
    rd(LFR_DET_ADDR, 8'h80, 8'h80);
    lfr_far_model_i.detect(1'b0);
    repeat (4) @(posedge core_clk);
    rd(LFR_DET_ADDR, 8'h00, 8'h80);
    for (int s = 0; s < 4; s++) begin
      wr(LFR_CTL_ADDR, 8'h0C | 8'(s));
      lfr_far_model_i.start();
      lfr_far_model_i.ticks(tmo[s] - 1);
      see(1, 1'b0);
      lfr_far_model_i.ticks(1);
      repeat (6) @(posedge core_clk);
      see(1, s != 0);
    end
    // A found SYNC stops the search before it can expire
    wr(LFR_CTL_ADDR, 8'h0D);
    lfr_far_model_i.start();
    lfr_far_model_i.ticks(4);
    syncFound <= 1'b1;
    @(posedge core_clk);
    syncFound <= 1'b0;
    @(posedge core_clk);
    lfr_far_model_i.ticks(8);
    repeat (6) @(posedge core_clk);
    see(1, 1'b0);
    $display("timeout done");
    wr(LFR_CTL_ADDR, 8'h00);
    softReset <= 1'b1;
    @(posedge core_clk);
    softReset <= 1'b0;
    @(posedge core_clk);
    rd(LFR_CTL_ADDR, LFR_CTL_RESET);
    see(1, 1'b0);
    $display("soft reset done");
    // Mid-run power-on reset reloads the defaults
    wr(LFR_CTL_ADDR, 8'h00);
    wr(LFR_STS_ADDR, 8'h00);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    see(0, 1'b0);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(LFR_CTL_ADDR, LFR_CTL_RESET);
    rd(LFR_STS_ADDR, LFR_STS_RESET);
    $display("power-on reset done");
    final_report();
  end
endmodule : lfr_regs_tb
